// *** testbench/dsa_assertions.sv ***
// Purpose: port checks for the debug serial front end
// Assumes: bit period of at least four clocks
// Notes:   bound into dsa_debug_serial
`timescale 1ns/1ns
module dsa_assertions
	import dsa_pkg::*;
(
	input wire logic                CLK_IN,
	input wire logic                RESET_IN,
	input wire logic                DEBUG_SERIAL_PIN_IN,
	input wire logic                DEBUG_SERIAL_PIN_OUT,
	input wire logic                DEBUG_SERIAL_PIN_OE_N_OUT,
	input wire logic                STOP_MODE_IN,
	input wire logic                SYS_RESET_REQ_OUT,
	input wire logic                TX_VALID_IN,
	input wire logic                TX_READY_OUT,
	input wire logic                BAUD_LOCKED_OUT,
	input wire logic [PERIOD_W-1:0] BAUD_PERIOD_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	property p_idle; !BAUD_LOCKED_OUT |-> DEBUG_SERIAL_PIN_OE_N_OUT && !TX_READY_OUT; endproperty
	a_idle: assert property (p_idle) else $error("active before lock");
	property p_lock; BAUD_LOCKED_OUT |=> BAUD_LOCKED_OUT; endproperty
	a_lock: assert property (p_lock) else $error("lock lost");
	property p_hold; BAUD_LOCKED_OUT && $past(BAUD_LOCKED_OUT) |-> $stable(BAUD_PERIOD_OUT); endproperty
	a_hold: assert property (p_hold) else $error("period moved");
	property p_range; $rose(BAUD_LOCKED_OUT) |-> BAUD_PERIOD_OUT inside {[MAX_RATE_DIV:MIN_RATE_DIV]}; endproperty
	a_range: assert property (p_range) else $error("period out of range");
	property p_go; TX_VALID_IN && TX_READY_OUT |=> !DEBUG_SERIAL_PIN_OE_N_OUT && !DEBUG_SERIAL_PIN_OUT; endproperty
	a_go: assert property (p_go) else $error("no start bit");
	property p_start; $fell(DEBUG_SERIAL_PIN_OE_N_OUT) |-> (!DEBUG_SERIAL_PIN_OUT) [*3]; endproperty
	a_start: assert property (p_start) else $error("start bit short");
	property p_stop; $rose(DEBUG_SERIAL_PIN_OE_N_OUT) |-> $past(DEBUG_SERIAL_PIN_OUT); endproperty
	a_stop: assert property (p_stop) else $error("released without stop");
	property p_sys; (STOP_MODE_IN && !DEBUG_SERIAL_PIN_IN) [*4] |-> SYS_RESET_REQ_OUT; endproperty
	a_sys: assert property (p_sys) else $error("no reset request");
	c_lock: cover property ($rose(BAUD_LOCKED_OUT));
	c_tx: cover property ($fell(DEBUG_SERIAL_PIN_OE_N_OUT));
	c_sys: cover property (SYS_RESET_REQ_OUT);
endmodule : dsa_assertions

bind dsa_debug_serial dsa_assertions u_dsa_assertions (
	.CLK_IN(CLK_IN),
	.RESET_IN(RESET_IN),
	.DEBUG_SERIAL_PIN_IN(DEBUG_SERIAL_PIN_IN),
	.DEBUG_SERIAL_PIN_OUT(DEBUG_SERIAL_PIN_OUT),
	.DEBUG_SERIAL_PIN_OE_N_OUT(DEBUG_SERIAL_PIN_OE_N_OUT),
	.STOP_MODE_IN(STOP_MODE_IN),
	.SYS_RESET_REQ_OUT(SYS_RESET_REQ_OUT),
	.TX_VALID_IN(TX_VALID_IN),
	.TX_READY_OUT(TX_READY_OUT),
	.BAUD_LOCKED_OUT(BAUD_LOCKED_OUT),
	.BAUD_PERIOD_OUT(BAUD_PERIOD_OUT)
);

// *** testbench/dsa_host.sv ***
// Purpose: debug host model on the serial line
// Assumes: line pulled high when released
// Notes:   bit time given in clocks
`timescale 1ns/1ns
module dsa_host (
	input  wire logic clk,
	input  wire logic line,
	output logic      drv
);
	initial drv = 1'b1;
	task automatic send(input logic [7:0] b, input int p, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			drv = f[i];
			repeat (p) @(negedge clk);
		end
		drv = 1'b1;
	endtask : send
	task automatic get(input int p, output logic [7:0] b);
		int n;
		n = 0;
		while (line && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		repeat (p + p / 2) @(negedge clk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = line;
			repeat (p) @(negedge clk);
		end
	endtask : get
	task automatic hold(input logic v);
		drv = v;
	endtask : hold
endmodule : dsa_host

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the debug serial front end
// Assumes: host opens with the calibration character
// Notes:   clock enable held high
`timescale 1ns/1ns
module tb;
	import dsa_pkg::*;
	logic                clk, rst, stop, tx_valid, drv, pin_out, oe_n, sys_req, rx_valid, rx_err, ready, locked;
	logic [7:0]          tx_data, rx_data, b;
	logic [PERIOD_W-1:0] period;
	logic [7:0]          rxq[$];
	int                  n_fail, check_count, n_err, cyc;
	wire                 line = (oe_n === 1'b0) ? pin_out : drv;
	dsa_host u_dsa_host (.clk(clk), .line(line), .drv(drv));
	dsa_debug_serial u_dsa_debug_serial (.CLK_IN(clk), .RESET_IN(rst), .CE_IN(1'b1),
		.DEBUG_SERIAL_PIN_IN(line), .DEBUG_SERIAL_PIN_OUT(pin_out), .DEBUG_SERIAL_PIN_OE_N_OUT(oe_n),
		.STOP_MODE_IN(stop), .SYS_RESET_REQ_OUT(sys_req), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid),
		.RX_FRAME_ERR_OUT(rx_err), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid), .TX_READY_OUT(ready),
		.BAUD_LOCKED_OUT(locked), .BAUD_PERIOD_OUT(period));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (rx_err === 1'b1) n_err <= n_err + 1;
		if (cyc == 40000)
		begin
			n_fail = n_fail + 1;
			end_of_test;
		end
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic t_calib(input int p);
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		rxq.delete();
		n_err = 0;
		chk(oe_n, 1);
		chk(ready, 0);
		u_dsa_host.send(CALIB_CHAR, p, 1'b1);
		repeat (8) @(negedge clk);
		chk(locked, 1);
		chk(period, p[9:0]);
		chk(10'(rxq.size() + n_err), 0);
	endtask : t_calib
	task automatic t_rx(input int p);
		logic [7:0] v[3] = '{8'hA5, 8'h01, 8'hFE};
		for (int i = 0; i < 3; i++) u_dsa_host.send(v[i], p, 1'b1);
		u_dsa_host.send(8'h55, p, 1'b0);
		repeat (2 * p) @(negedge clk);
		chk(10'(rxq.size()), 3);
		for (int i = 0; i < 3; i++) chk(rxq[i], v[i]);
		chk(10'(n_err), 1);
	endtask : t_rx
	task automatic t_tx(input int p);
		chk(ready, 1);
		tx_data = 8'h4B;
		tx_valid = 1'b1;
		@(negedge clk);
		tx_valid = 1'b0;
		u_dsa_host.get(p, b);
		chk(b, 8'h4B);
		chk(line, 1);
		repeat (p) @(negedge clk);
		chk(oe_n, 1);
	endtask : t_tx
	task automatic t_stop;
		stop = 1'b1;
		repeat (4) @(negedge clk);
		chk(sys_req, 0);
		u_dsa_host.hold(1'b0);
		repeat (6) @(negedge clk);
		chk(sys_req, 1);
		stop = 1'b0;
		repeat (4) @(negedge clk);
		chk(sys_req, 0);
		u_dsa_host.hold(1'b1);
	endtask : t_stop
	task automatic end_of_test;
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		{rst, stop, tx_valid, tx_data} = {1'b1, 1'b0, 1'b0, 8'h00};
		n_fail = 0;
		check_count = 0;
		n_err = 0;
		cyc = 0;
		t_calib(16);
		t_rx(16);
		t_tx(16);
		t_stop;
		t_calib(4);
		t_rx(4);
		t_calib(512);
		t_tx(512);
		end_of_test;
	end
endmodule : tb

// *** verilog/dsa_baud_if.sv ***
// Purpose: carries the measured bit period between autobaud and transmitter
// Assumes: single clock domain
// Notes:   period is zero until calibration ends
`timescale 1ns/1ns
interface dsa_baud_if;
	logic [dsa_pkg::PERIOD_W-1:0] period;
	logic                         locked;
	modport src (output period, output locked);
	modport dst (input  period, input  locked);
endinterface : dsa_baud_if

// *** verilog/dsa_debug_serial.sv ***
// Purpose: single-wire serial front end of the onchip debug unit with autobaud
// Assumes: host opens with the calibration character after every reset
// Notes:   pin input passes two flip-flops before use
//
// How it works
// [R1] Characters are one low start bit, eight data bits lsb first, then one high stop bit.
// [R2] After reset nothing is sent or received until the low run of the host's first character has been measured.
// [R3] The host sends 80H first so the bit rate can be measured.
// [R4] The low run of the first character, start plus seven data bits, is timed and sets the bit period.
// [R5] Measurement and bit timing both count system clock cycles.
// [R6] The period counter is wide enough for clock divided by 512.
// [R7] The host should keep below clock divided by 8.
// [R8] Reception works up to clock divided by 4 on clean lines.
// [R9] A low debug pin while in stop mode requests a full system reset.
// [R10] The line idles high; start is low and stop is high for one bit period each.
// [R11] Data bits are sampled at the middle of their period from the measured interval.
`timescale 1ns/1ns
module dsa_debug_serial
	import dsa_pkg::*;
(
	// clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       RESET_IN,
	input  wire logic       CE_IN,
	// debug serial pin
	input  wire logic       DEBUG_SERIAL_PIN_IN,
	output logic            DEBUG_SERIAL_PIN_OUT,
	output logic            DEBUG_SERIAL_PIN_OE_N_OUT,
	// power state
	input  wire logic       STOP_MODE_IN,
	output logic            SYS_RESET_REQ_OUT,
	// received characters
	output logic [7:0]      RX_DATA_OUT,
	output logic            RX_VALID_OUT,
	output logic            RX_FRAME_ERR_OUT,
	// characters to send
	input  wire logic [7:0] TX_DATA_IN,
	input  wire logic       TX_VALID_IN,
	output logic            TX_READY_OUT,
	// calibration status
	output logic            BAUD_LOCKED_OUT,
	output logic [dsa_pkg::PERIOD_W-1:0] BAUD_PERIOD_OUT
);
	// -----------------------------------------------------------------
	// pin synchroniser
	// -----------------------------------------------------------------
	logic       sync1;
	logic       sync2;
	logic       line_q;
	logic       next_sync1;
	logic       next_sync2;
	logic       next_line_q;

	always_comb
	begin
		next_sync1  = DEBUG_SERIAL_PIN_IN;
		next_sync2  = sync1;
		next_line_q = sync2;
	end

	always_ff @(posedge CLK_IN)
	begin
		if (RESET_IN)
		begin
			sync1  <= 1'b1;
			sync2  <= 1'b1;
			line_q <= 1'b1;
		end
		else if (CE_IN)
		begin
			sync1  <= next_sync1;
			sync2  <= next_sync2;
			line_q <= next_line_q;
		end
	end

	// -----------------------------------------------------------------
	// stop mode wake reset
	// -----------------------------------------------------------------
	logic next_sys_rst;

	always_comb
		next_sys_rst = STOP_MODE_IN && !sync2;                          // see [R9]

	always_ff @(posedge CLK_IN)
	begin
		if (RESET_IN)
			SYS_RESET_REQ_OUT <= 1'b0;
		else if (CE_IN)
			SYS_RESET_REQ_OUT <= next_sys_rst;
	end

	// -----------------------------------------------------------------
	// autobaud measurement
	// -----------------------------------------------------------------
	dsa_baud_if baud ();
	logic                 locked;
	logic                 next_locked;
	logic                 measuring;
	logic                 next_measuring;
	logic [MEAS_W-1:0]    meas;
	logic [MEAS_W-1:0]    next_meas;
	logic [PERIOD_W-1:0]  period;
	logic [PERIOD_W-1:0]  next_period;
	logic                 fall;

	assign fall = line_q && !sync2;

	always_comb
	begin
		next_locked    = locked;
		next_measuring = measuring;
		next_meas      = meas;
		next_period    = period;
		if (!locked)                                                    // see [R2]
		begin
			if (!measuring && fall)
			begin
				next_measuring = 1'b1;
				next_meas      = '0;
			end
			else if (measuring && !sync2)
				next_meas = meas + 1'b1;                                // see [R5]
			else if (measuring && sync2)
			begin
				// low run is eight bit times, so divide by eight
				next_measuring = 1'b0;
				next_locked    = 1'b1;                                  // see [R4]
				next_period    = meas[MEAS_W-1:$clog2(AUTOBAUD_LOWS)] + 1'b1;   // see [R6]
			end
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (RESET_IN)
		begin
			locked    <= 1'b0;
			measuring <= 1'b0;
			meas      <= '0;
			period    <= '0;
		end
		else if (CE_IN)
		begin
			locked    <= next_locked;
			measuring <= next_measuring;
			meas      <= next_meas;
			period    <= next_period;
		end
	end

	assign baud.period     = period;
	assign baud.locked     = locked;
	assign BAUD_LOCKED_OUT = locked;
	assign BAUD_PERIOD_OUT = period;

	// -----------------------------------------------------------------
	// receiver
	// -----------------------------------------------------------------
	dsa_rx_state_t        rx_state;
	dsa_rx_state_t        next_rx_state;
	logic [PERIOD_W-1:0]  rx_cnt;
	logic [PERIOD_W-1:0]  next_rx_cnt;
	logic [3:0]           rx_idx;
	logic [3:0]           next_rx_idx;
	logic [7:0]           rx_sh;
	logic [7:0]           next_rx_sh;
	logic [7:0]           next_rx_data;
	logic                 next_rx_valid;
	logic                 next_rx_err;
	logic                 rx_tick;
	logic [PERIOD_W-1:0]  half;

	assign half    = {1'b0, period[PERIOD_W-1:1]};                   // see [R8]
	assign rx_tick = (rx_cnt == period - 1'b1);

	always_comb
	begin
		next_rx_state = rx_state;
		next_rx_cnt   = rx_tick ? '0 : rx_cnt + 1'b1;
		next_rx_idx   = rx_idx;
		next_rx_sh    = rx_sh;
		next_rx_data  = RX_DATA_OUT;
		next_rx_valid = 1'b0;
		next_rx_err   = 1'b0;
		unique case (rx_state)
			DSA_RX_IDLE:
			begin
				next_rx_cnt = '0;
				if (locked && measuring == 1'b0 && fall)
					next_rx_state = DSA_RX_START;
			end
			DSA_RX_START:
				// wait half a period to land mid bit
				if (rx_cnt == half)                                     // see [R11]
				begin
					next_rx_cnt   = '0;
					next_rx_idx   = BIT_IDX_RESET;
					next_rx_state = sync2 ? DSA_RX_IDLE : DSA_RX_DATA;  // see [R10]
				end
			DSA_RX_DATA:
				if (rx_tick)
				begin
					next_rx_sh  = {sync2, rx_sh[7:1]};                  // see [R1]
					next_rx_idx = rx_idx + 1'b1;
					if (rx_idx == LAST_DATA_IDX)
						next_rx_state = DSA_RX_STOP;
				end
			DSA_RX_STOP:
				if (rx_tick)
				begin
					next_rx_state = DSA_RX_IDLE;
					next_rx_data  = rx_sh;
					next_rx_valid = sync2;
					next_rx_err   = !sync2;                             // see [R10]
				end
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (RESET_IN)
		begin
			rx_state         <= DSA_RX_IDLE;
			rx_cnt           <= '0;
			rx_idx           <= BIT_IDX_RESET;
			rx_sh            <= 8'h00;
			RX_DATA_OUT      <= 8'h00;
			RX_VALID_OUT     <= 1'b0;
			RX_FRAME_ERR_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			rx_state         <= next_rx_state;
			rx_cnt           <= next_rx_cnt;
			rx_idx           <= next_rx_idx;
			rx_sh            <= next_rx_sh;
			RX_DATA_OUT      <= next_rx_data;
			RX_VALID_OUT     <= next_rx_valid;
			RX_FRAME_ERR_OUT <= next_rx_err;
		end
	end

	// -----------------------------------------------------------------
	// transmitter
	// -----------------------------------------------------------------
	dsa_tx u_tx (
		.clk      (CLK_IN),
		.rst      (RESET_IN),
		.ce       (CE_IN),
		.baud     (baud.dst),
		.valid    (TX_VALID_IN),
		.data     (TX_DATA_IN),
		.ready    (TX_READY_OUT),
		.pin_o    (DEBUG_SERIAL_PIN_OUT),
		.pin_oe_n (DEBUG_SERIAL_PIN_OE_N_OUT)
	);
endmodule : dsa_debug_serial

// *** verilog/dsa_pkg.sv ***
// Purpose: shared constants for the debug serial autobaud front end
// Assumes: 20 MHz system clock
// Notes:   all counts are in system clock cycles
package dsa_pkg;
	// -----------------------------------------------------------------
	// framing and rates
	// -----------------------------------------------------------------
	localparam int          DATA_BITS       = 8;
	localparam int          AUTOBAUD_LOWS   = 8;
	localparam int          MIN_RATE_DIV    = 512;
	localparam int          MAX_RATE_DIV    = 4;
	localparam int          PERIOD_W        = $clog2(MIN_RATE_DIV) + 1;
	localparam int          MEAS_W          = PERIOD_W + 3;
	localparam logic [7:0]  CALIB_CHAR      = 8'h80;
	localparam logic [3:0]  BIT_IDX_RESET   = 4'h0;
	localparam logic [3:0]  LAST_DATA_IDX   = 4'h7;

	typedef enum logic [1:0] {DSA_RX_IDLE, DSA_RX_START, DSA_RX_DATA, DSA_RX_STOP} dsa_rx_state_t;
	typedef enum logic [1:0] {DSA_TX_IDLE, DSA_TX_START, DSA_TX_DATA, DSA_TX_STOP} dsa_tx_state_t;
endpackage : dsa_pkg

// *** verilog/dsa_tx.sv ***
// Purpose: character transmitter for the debug serial pin
// Assumes: period comes from the autobaud measurement
// Notes:   output enable low while driving
`timescale 1ns/1ns
module dsa_tx
	import dsa_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  ce,
	dsa_baud_if.dst    baud,
	input  wire logic  valid,
	input  wire logic  [7:0] data,
	output logic       ready,
	output logic       pin_o,
	output logic       pin_oe_n
);
	dsa_tx_state_t                state;
	dsa_tx_state_t                next_state;
	logic          [PERIOD_W-1:0] cnt;
	logic          [PERIOD_W-1:0] next_cnt;
	logic          [3:0]          idx;
	logic          [3:0]          next_idx;
	logic          [7:0]          shreg;
	logic          [7:0]          next_shreg;
	logic                         tick;
	logic                         next_pin_o;
	logic                         next_pin_oe_n;

	assign tick  = (cnt == baud.period - 1'b1);
	assign ready = (state == DSA_TX_IDLE) && baud.locked;

	always_comb
	begin
		next_state = state;
		next_cnt   = tick ? '0 : cnt + 1'b1;
		next_idx   = idx;
		next_shreg = shreg;
		unique case (state)
			DSA_TX_IDLE:
			begin
				next_cnt = '0;
				if (valid && ready)                                   // see [R2]
				begin
					next_shreg = data;
					next_state = DSA_TX_START;
				end
			end
			DSA_TX_START:
				if (tick)
				begin
					next_state = DSA_TX_DATA;
					next_idx   = BIT_IDX_RESET;
				end
			DSA_TX_DATA:
				if (tick)
				begin
					next_shreg = {1'b1, shreg[7:1]};                   // see [R1]
					next_idx   = idx + 1'b1;
					if (idx == LAST_DATA_IDX)
						next_state = DSA_TX_STOP;
				end
			DSA_TX_STOP:
				if (tick)
					next_state = DSA_TX_IDLE;
		endcase
		// low start, lsb first data, high stop, released when idle
		next_pin_o    = (next_state == DSA_TX_START) ? 1'b0 :
		                (next_state == DSA_TX_DATA)  ? next_shreg[0] : 1'b1;   // see [R10]
		next_pin_oe_n = (next_state == DSA_TX_IDLE);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state    <= DSA_TX_IDLE;
			cnt      <= '0;
			idx      <= BIT_IDX_RESET;
			shreg    <= 8'hFF;
			pin_o    <= 1'b1;
			pin_oe_n <= 1'b1;
		end
		else if (ce)
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			idx      <= next_idx;
			shreg    <= next_shreg;
			pin_o    <= next_pin_o;
			pin_oe_n <= next_pin_oe_n;
		end
	end
endmodule : dsa_tx
